/* hw/swo_ctrl.sv */
// Switch output controller with its AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "swo_map.svh"
module swo_ctrl #(
    parameter int unsigned TICK_CYCLES = `SWO_TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [31:0] meas_value,
    input  wire logic        alarm,
    input  wire logic        warning,
    input  wire logic [5:0]  dig_src,
    output logic             switch_closed
);

    // ======================================================================
    // Helper functions.

    // Maps an IEEE single to an unsigned key whose order is the numeric order.
    // Both zeros map to the same key so that +0 and -0 compare equal.
    function automatic logic [31:0] f_key(input logic [31:0] x);
        logic [31:0] k;
        if (x[30:0] == 31'h0000_0000) begin
            k = 32'h8000_0000;
        end else if (x[31]) begin
            k = ~x;
        end else begin
            k = x ^ 32'h8000_0000;
        end
        return k;
    endfunction

    // Strict greater-than on two singles. NaN gets no special treatment and
    // orders by its bit pattern, so software must not program one.
    function automatic logic f_gt(input logic [31:0] a, input logic [31:0] b);
        return f_key(a) > f_key(b);
    endfunction

    // Delay entries beyond the top of the range are clipped to it.
    function automatic logic [`SWO_DLY_W-1:0] f_clamp(input logic [31:0] v);
        logic [`SWO_DLY_W-1:0] r;
        if (v > 32'(`SWO_DLY_MAX)) begin
            r = `SWO_DLY_MAX;
        end else begin
            r = v[`SWO_DLY_W-1:0];
        end
        return r;
    endfunction

    // ======================================================================
    // Declarations.
    logic [2:0]            func_r,    func_nxt;
    logic [2:0]            src_r,     src_nxt;
    logic [1:0]            diag_r,    diag_nxt;
    logic [1:0]            fail_r,    fail_nxt;
    logic                  inv_r,     inv_nxt;
    logic                  limen_r,   limen_nxt;
    logic [31:0]           on_val_r,  on_val_nxt;
    logic [31:0]           off_val_r, off_val_nxt;
    logic [`SWO_DLY_W-1:0] on_dly_r,  on_dly_nxt;
    logic [`SWO_DLY_W-1:0] off_dly_r, off_dly_nxt;
    logic                  wr_pend_r, wr_pend_nxt;
    logic [7:0]            waddr_r,   waddr_nxt;
    logic [31:0]           hrdata_r,  hrdata_nxt;
    logic                  hready_r,  hready_nxt;
    logic                  limit_r,   limit_nxt;
    logic                  sw_r,      sw_nxt;
    logic                  hresp_r;
    logic                  tick;
    logic                  addr_ok;
    logic                  on_cond;
    logic                  off_cond;
    logic                  computed;
    logic                  src_bit;
    logic                  diag_evt;
    logic [7:0]            raddr;
    logic [31:0]           status;

    swo_dly_if on_if ();
    swo_dly_if off_if ();

    // ======================================================================
    // Timebase and the two qualification timers.
    // The timebase runs free, so the first tick after arming comes anywhere
    // within one tick period: a delay may end up to one tenth early.
    swo_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .tick    (tick)
    );

    swo_delay u_on_dly (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .dly     (on_if.timer)
    );

    swo_delay u_off_dly (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .dly     (off_if.timer)
    );

    // ======================================================================
    // Bus slave: address phase decode, write commit in the data phase.
    // Writes land one edge after the address phase, so reads are served from
    // the next-state values; a read right after a write sees the new value.
    // Keep the bus idle while ce is low: an address phase ending on a frozen
    // edge is dropped, so ready falls one cycle after ce to stall the master.
    assign addr_ok = hsel && htrans[1] && hready && ce;
    assign raddr   = {haddr[7:2], 2'b00};

    always_comb begin
        func_nxt    = func_r;
        src_nxt     = src_r;
        diag_nxt    = diag_r;
        fail_nxt    = fail_r;
        inv_nxt     = inv_r;
        limen_nxt   = limen_r;
        on_val_nxt  = on_val_r;
        off_val_nxt = off_val_r;
        on_dly_nxt  = on_dly_r;
        off_dly_nxt = off_dly_r;
        wr_pend_nxt = wr_pend_r;
        waddr_nxt   = waddr_r;
        if (ce) begin
            if (wr_pend_r) begin
                unique case (waddr_r)
                    `SWO_OFS_CTRL: begin
                        func_nxt  = hwdata[`SWO_CTRL_FUNC_LSB +: 3];
                        src_nxt   = hwdata[`SWO_CTRL_SRC_LSB +: 3];
                        diag_nxt  = hwdata[`SWO_CTRL_DIAG_LSB +: 2];
                        fail_nxt  = hwdata[`SWO_CTRL_FAIL_LSB +: 2];
                        inv_nxt   = hwdata[`SWO_CTRL_INV_BIT];
                        limen_nxt = hwdata[`SWO_CTRL_LIMEN_BIT];
                    end
                    `SWO_OFS_ON_VAL:  on_val_nxt  = hwdata;
                    `SWO_OFS_OFF_VAL: off_val_nxt = hwdata;
                    `SWO_OFS_ON_DLY:  on_dly_nxt  = f_clamp(hwdata);
                    `SWO_OFS_OFF_DLY: off_dly_nxt = f_clamp(hwdata);
                    default: ;
                endcase
            end
            wr_pend_nxt = addr_ok && hwrite;
            waddr_nxt   = {haddr[7:2], 2'b00};
        end
    end

    // Status word shows live state; the switch bit is the driven output.
    always_comb begin
        status     = 32'h0000_0000;
        status[0]  = sw_r;
        status[1]  = limit_r;
        status[2]  = on_if.arm;
        status[3]  = off_if.arm;
        status[4]  = alarm;
        status[5]  = warning;
    end

    // Read data and ready. Unmapped offsets read as zero and take writes
    // silently; the answer is always OKAY.
    always_comb begin
        hrdata_nxt = hrdata_r;
        hready_nxt = ce;
        if (addr_ok && !hwrite) begin
            hrdata_nxt = 32'h0000_0000;
            unique case (raddr)
                `SWO_OFS_CTRL: begin
                    hrdata_nxt[`SWO_CTRL_FUNC_LSB +: 3] = func_nxt;
                    hrdata_nxt[`SWO_CTRL_SRC_LSB +: 3]  = src_nxt;
                    hrdata_nxt[`SWO_CTRL_DIAG_LSB +: 2] = diag_nxt;
                    hrdata_nxt[`SWO_CTRL_FAIL_LSB +: 2] = fail_nxt;
                    hrdata_nxt[`SWO_CTRL_INV_BIT]       = inv_nxt;
                    hrdata_nxt[`SWO_CTRL_LIMEN_BIT]     = limen_nxt;
                end
                `SWO_OFS_ON_VAL:  hrdata_nxt = on_val_nxt;
                `SWO_OFS_OFF_VAL: hrdata_nxt = off_val_nxt;
                `SWO_OFS_ON_DLY:  hrdata_nxt = 32'(on_dly_nxt);
                `SWO_OFS_OFF_DLY: hrdata_nxt = 32'(off_dly_nxt);
                `SWO_OFS_STATUS:  hrdata_nxt = status;
                default: ;
            endcase
        end
    end

    // Configuration and bus registers; reset gives the factory settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_r    <= 3'(swo_pkg::SWO_FN_OFF);
            src_r     <= 3'(swo_pkg::SWO_SRC_OFF);
            diag_r    <= 2'(swo_pkg::SWO_DG_ALARM);
            fail_r    <= 2'(swo_pkg::SWO_FL_OPEN);
            inv_r     <= 1'b0;
            limen_r   <= 1'b0;
            on_val_r  <= `SWO_RST_VAL;
            off_val_r <= `SWO_RST_VAL;
            on_dly_r  <= `SWO_RST_DLY;
            off_dly_r <= `SWO_RST_DLY;
            wr_pend_r <= 1'b0;
            waddr_r   <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
            hready_r  <= 1'b1;
            hresp_r   <= 1'b0;
        end else begin
            func_r    <= func_nxt;
            src_r     <= src_nxt;
            diag_r    <= diag_nxt;
            fail_r    <= fail_nxt;
            inv_r     <= inv_nxt;
            limen_r   <= limen_nxt;
            on_val_r  <= on_val_nxt;
            off_val_r <= off_val_nxt;
            on_dly_r  <= on_dly_nxt;
            off_dly_r <= off_dly_nxt;
            wr_pend_r <= wr_pend_nxt;
            waddr_r   <= waddr_nxt;
            hrdata_r  <= hrdata_nxt;
            hready_r  <= hready_nxt;
            hresp_r   <= 1'b0;
        end
    end

    // ======================================================================
    // Limit comparison. Equal thresholds behave as the switch-on-above case.
    // Both compares are strict, so a value sitting exactly on a threshold
    // leaves the limit state where it was.
    always_comb begin
        if (f_gt(off_val_r, on_val_r)) begin
            on_cond  = f_gt(on_val_r, meas_value);
            off_cond = f_gt(meas_value, off_val_r);
        end else begin
            on_cond  = f_gt(meas_value, on_val_r);
            off_cond = f_gt(off_val_r, meas_value);
        end
    end

    // Each timer runs only while its transition is wanted and pending, so a
    // value that wanders back into the band restarts it.
    assign on_if.tick  = tick;
    assign on_if.lim   = on_dly_r;
    assign on_if.arm   = limen_r && !limit_r && on_cond;
    assign off_if.tick = tick;
    assign off_if.lim  = off_dly_r;
    assign off_if.arm  = limen_r && limit_r && off_cond;

    // Limit state holds between the thresholds; without an assigned
    // variable it rests open.
    always_comb begin
        limit_nxt = limit_r;
        if (ce) begin
            if (!limen_r) begin
                limit_nxt = 1'b0;
            end else if (on_if.done) begin
                limit_nxt = 1'b1;
            end else if (off_if.done) begin
                limit_nxt = 1'b0;
            end
        end
    end

    // ======================================================================
    // Source select and diagnostic category decode.
    // Source Off and the spare code give open before inversion, so an
    // unconfigured digital output rests in the safe state.
    always_comb begin
        unique case (swo_pkg::swo_src_t'(src_r))
            swo_pkg::SWO_SRC_AD1: src_bit = dig_src[0];
            swo_pkg::SWO_SRC_AD2: src_bit = dig_src[1];
            swo_pkg::SWO_SRC_DO1: src_bit = dig_src[2];
            swo_pkg::SWO_SRC_DO2: src_bit = dig_src[3];
            swo_pkg::SWO_SRC_DO3: src_bit = dig_src[4];
            swo_pkg::SWO_SRC_DO4: src_bit = dig_src[5];
            default:              src_bit = 1'b0;
        endcase
    end

    always_comb begin
        unique case (swo_pkg::swo_diag_t'(diag_r))
            swo_pkg::SWO_DG_ALARM_WARN: diag_evt = alarm || warning;
            swo_pkg::SWO_DG_WARN:       diag_evt = warning;
            default:                    diag_evt = alarm;
        endcase
    end

    // ======================================================================
    // Output composition: function, then failure mode, then inversion.
    // Undefined function codes fall back to open, the safe state.
    // The failure mode is left out in diagnostic function, where the
    // selected diagnostic event already decides the output.
    always_comb begin
        unique case (swo_pkg::swo_func_t'(func_r))
            swo_pkg::SWO_FN_ON:    computed = 1'b1;
            swo_pkg::SWO_FN_DIAG:  computed = !diag_evt;
            swo_pkg::SWO_FN_LIMIT: computed = limit_r;
            swo_pkg::SWO_FN_DOUT:  computed = src_bit;
            default:               computed = 1'b0;
        endcase
        if (alarm && (func_r == 3'(swo_pkg::SWO_FN_LIMIT) ||
                      func_r == 3'(swo_pkg::SWO_FN_DOUT))) begin
            if (fail_r == 2'(swo_pkg::SWO_FL_OPEN)) begin
                computed = 1'b0;
            end else if (fail_r == 2'(swo_pkg::SWO_FL_CLOSED)) begin
                computed = 1'b1;
            end
        end
        sw_nxt = ce ? (computed ^ inv_r) : sw_r;
    end

    // Logic state registers; the output comes straight from sw_r.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limit_r <= 1'b0;
            sw_r    <= 1'b0;
        end else begin
            limit_r <= limit_nxt;
            sw_r    <= sw_nxt;
        end
    end

    // Every output leaves straight from a register.
    assign switch_closed = sw_r;
    assign hreadyout     = hready_r;
    assign hrdata        = hrdata_r;
    assign hresp         = hresp_r;

endmodule // swo_ctrl

/* hw/swo_delay.sv */
// Qualification timer: reports done once its condition held over the programmed number of ticks.
`timescale 1ns/100ps
`include "swo_map.svh"
module swo_delay (
    input  wire logic    hclk,
    input  wire logic    hresetn,
    input  wire logic    ce,
    swo_dly_if.timer     dly
);
    logic [`SWO_DLY_W-1:0] cnt_r;
    logic [`SWO_DLY_W-1:0] cnt_nxt;

    // ======================================================================
    // Count ticks while armed; any lapse of the condition restarts from zero.
    always_comb begin
        cnt_nxt = cnt_r;
        if (ce) begin
            if (!dly.arm) begin
                cnt_nxt = `SWO_RST_DLY;
            end else if (dly.tick && cnt_r < dly.lim) begin
                cnt_nxt = cnt_r + `SWO_DLY_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= `SWO_RST_DLY;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // A zero delay qualifies at once.
    assign dly.done = dly.arm && (cnt_r >= dly.lim);
endmodule // swo_delay

/* hw/swo_dly_if.sv */
// Carrier between the controller and one qualification delay timer.
`timescale 1ns/100ps
`include "swo_map.svh"
interface swo_dly_if;
    logic                  tick;
    logic                  arm;
    logic [`SWO_DLY_W-1:0] lim;
    logic                  done;
    modport owner (output tick, output arm, output lim, input done);
    modport timer (input tick, input arm, input lim, output done);
endinterface

/* hw/swo_map.svh */
// Register offsets, field positions, reset values and timing counts of the switch output block.
`ifndef SWO_MAP_SVH
`define SWO_MAP_SVH

// ==========================================================================
// Register byte offsets.
`define SWO_OFS_CTRL        8'h00
`define SWO_OFS_ON_VAL      8'h04
`define SWO_OFS_OFF_VAL     8'h08
`define SWO_OFS_ON_DLY      8'h0c
`define SWO_OFS_OFF_DLY     8'h10
`define SWO_OFS_STATUS      8'h14

// ==========================================================================
// Control register field positions.
`define SWO_CTRL_FUNC_LSB   0
`define SWO_CTRL_SRC_LSB    4
`define SWO_CTRL_DIAG_LSB   8
`define SWO_CTRL_FAIL_LSB   12
`define SWO_CTRL_INV_BIT    16
`define SWO_CTRL_LIMEN_BIT  20

// ==========================================================================
// Reset values.
`define SWO_RST_VAL         32'h0000_0000
`define SWO_RST_DLY         11'h000

// ==========================================================================
// Timing: delays count in tenths of a second.
`define SWO_DLY_W           11
`define SWO_DLY_MAX         11'h3e8
`define SWO_TICK_MS         100
`define SWO_CLK_MHZ         125
`define SWO_TICK_CYCLES     (`SWO_TICK_MS * 1000 * `SWO_CLK_MHZ)

`endif

/* hw/swo_pkg.sv */
// Types shared by the switch output block.
package swo_pkg;

    // ======================================================================
    // Output function, status source, diagnostic category, failure mode.
    typedef enum logic [2:0] {
        SWO_FN_OFF, SWO_FN_ON, SWO_FN_DIAG, SWO_FN_LIMIT, SWO_FN_DOUT
    } swo_func_t;

    typedef enum logic [2:0] {
        SWO_SRC_OFF, SWO_SRC_AD1, SWO_SRC_AD2,
        SWO_SRC_DO1, SWO_SRC_DO2, SWO_SRC_DO3, SWO_SRC_DO4
    } swo_src_t;

    typedef enum logic [1:0] {
        SWO_DG_ALARM, SWO_DG_ALARM_WARN, SWO_DG_WARN
    } swo_diag_t;

    typedef enum logic [1:0] {
        SWO_FL_ACTUAL, SWO_FL_OPEN, SWO_FL_CLOSED
    } swo_fail_t;

endpackage

/* hw/swo_tick.sv */
// Slow timebase: one-cycle pulse every tenth of a second.
`timescale 1ns/100ps
module swo_tick #(
    parameter int unsigned TICK_CYCLES = 12500000
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    output logic      tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // ======================================================================
    // Free-running divider; frozen with the clock enable.
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (ce) begin
            if (cnt_r >= TICK_CYCLES - 1) begin
                cnt_nxt  = 32'h0000_0000;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end else begin
            tick_nxt = tick_r;
        end
    end

    // Registers only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // swo_tick

/* verification/switch_output_controller_tb_top.sv */
// Self-checking bench for the switch output controller.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module switch_output_controller_tb_top;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, alarm, warning;
    logic        sw_c, load_on, rd_q;
    logic [31:0] haddr, hwdata, hrdata, meas;
    logic [1:0]  htrans;
    logic [5:0]  dig_src;
    logic [63:0] q_exp[$];
    logic [63:0] m;
    int          failures, total_checks, cyc, i;
    swo_ctrl #(.TICK_CYCLES(10)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .meas_value(meas), .alarm(alarm), .warning(warning), .dig_src(dig_src),
        .switch_closed(sw_c));
    swo_load u_load (.hclk(hclk), .switch_closed(sw_c), .conducting(load_on));
    // ==================================================================
    // Clock, hang guard and the read monitor that drains the notes.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
        if (rd_q && hreadyout === 1'b1) begin
            m = q_exp.pop_front();
            `CHK(hrdata & m[63:32], m[31:0])
            if (m[63:32] == 32'h1) `CHK(load_on, m[0])
        end
        rd_q <= hsel && htrans[1] && !hwrite && hreadyout && ce;
    end
    // One single transfer; requests change only right after an edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        q_exp.push_back({k, e});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    // Lets the output settle, then reads it back through the status word.
    task automatic sw(input logic e);
        repeat (3) @(posedge hclk);
        rd(8'h14, {31'h0, e}, 32'h1);
    endtask
    task automatic lm(input logic [31:0] v, input logic e);
        meas <= v;
        sw(e);
    endtask
    function automatic logic [31:0] ctl(logic [2:0] f, logic [2:0] s, logic [1:0] c,
                                        logic [1:0] l, logic v, logic e);
        return {11'h0, e, 3'h0, v, 2'h0, l, 2'h0, c, 1'h0, s, 1'h0, f};
    endfunction
    task automatic done(input string n);
        $display("TB: test %s done", n);
    endtask
    task automatic end_sim;
        $display("TB: checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==================================================================
    // Main sequence.
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, meas, alarm, warning, dig_src} = '0;
        ce = 1'b1;
        void'($urandom(32'haf1cb8f4));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (i = 1; i < 6; i++) rd(8'(4 * i), 32'h0, 32'hffffffff);
        rd(8'h00, 32'h0000_1000, 32'hffffffff);
        wr(8'h40, $urandom);
        rd(8'h40, 32'h0, 32'hffffffff);
        done("reset");
        for (i = 0; i < 16; i++) begin
            wr(8'h00, ctl(3'(i % 8), 3'd0, 2'd0, 2'd0, i[3], 1'b0));
            sw(((i % 8) inside {1, 2}) ^ i[3]);
        end
        for (i = 0; i < 16; i++) begin
            alarm <= i[0];
            warning <= i[1];
            wr(8'h00, ctl(3'd2, 3'd0, 2'(i / 4), 2'd0, 1'b0, 1'b0));
            sw(!(i / 4 == 1 ? i[0] | i[1] : (i / 4 == 2 ? i[1] : i[0])));
        end
        alarm <= 1'b0;
        warning <= 1'b0;
        for (i = 0; i < 8; i++) begin
            dig_src <= 6'($urandom);
            wr(8'h00, ctl(3'd4, 3'(i), 2'd0, 2'd0, 1'b0, 1'b0));
            sw((i inside {[1:6]}) ? dig_src[i - 1] : 1'b0);
        end
        for (i = 0; i < 12; i++) begin
            alarm <= i[1];
            dig_src <= {5'h0, i[0]};
            wr(8'h00, ctl(3'd4, 3'd1, 2'd0, 2'(i / 4), 1'b0, 1'b0));
            sw((i[1] && i / 4 != 0) ? (i / 4 == 2) : i[0]);
        end
        alarm <= 1'b0;
        done("modes");
        wr(8'h04, 32'h41200000);
        wr(8'h08, 32'h40a00000);
        wr(8'h00, ctl(3'd3, 3'd0, 2'd0, 2'd1, 1'b0, 1'b1));
        lm(32'h40f00000, 1'b0);
        lm(32'h41400000, 1'b1);
        lm(32'h40f00000, 1'b1);
        lm(32'h40000000, 1'b0);
        wr(8'h04, 32'h40a00000);
        wr(8'h08, 32'h41200000);
        lm(32'h40000000, 1'b1);
        lm(32'h40f00000, 1'b1);
        lm(32'h41400000, 1'b0);
        wr(8'h04, 32'hbf800000);
        wr(8'h08, 32'hc0a00000);
        lm(32'hbf000000, 1'b1);
        lm(32'hc0c00000, 1'b0);
        done("limit");
        wr(8'h0c, 32'h7d0);
        rd(8'h0c, 32'h3e8, 32'hffffffff);
        wr(8'h0c, 32'h3);
        wr(8'h10, 32'h2);
        meas <= 32'h0;
        repeat (12) @(posedge hclk);
        lm(32'hc0c00000, 1'b0);
        repeat (40) @(posedge hclk);
        lm(32'h0, 1'b0);
        repeat (30) @(posedge hclk);
        sw(1'b1);
        meas <= 32'hc0c00000;
        repeat (2) @(posedge hclk);
        sw(1'b1);
        repeat (30) @(posedge hclk);
        sw(1'b0);
        wr(8'h0c, 32'h0);
        ce <= 1'b0;
        meas <= 32'h0; // Would close at once if the freeze failed.
        repeat (4) @(posedge hclk);
        ce <= 1'b1;
        sw(1'b1);
        done("delay");
        repeat (3) @(posedge hclk);
        end_sim();
    end
endmodule // switch_output_controller_tb_top
bind swo_ctrl swo_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alarm(alarm),
    .warning(warning), .dig_src(dig_src), .switch_closed(switch_closed));

/* verification/swo_ctrl_props.sv */
// Concurrent checks on the ports of the switch output controller.
`timescale 1ns/100ps
module swo_ctrl_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        alarm,
    input wire logic        warning,
    input wire logic [5:0]  dig_src,
    input wire logic        switch_closed
);
    logic [31:0] ctl_r, ctl_nxt;
    logic [41:0] prv_r, cur;
    logic [1:0]  ph_r, ph_nxt, q_r, q_nxt;
    logic        tk, ev, b, exp;
    // ==================================================================
    // Shadow of the control word and a count of quiet cycles.
    always_comb begin
        tk = hsel && htrans[1] && hready && ce;
        ph_nxt = {tk && !hwrite && haddr[7:2] == 6'h05, tk && hwrite && haddr[7:2] == 6'h00};
        ctl_nxt = (ph_r[0] && ce) ? hwdata : ctl_r;
        cur = {ctl_r, alarm, warning, dig_src, ce, 1'b0};
        // Any change restarts the count, so outputs are judged only once settled.
        q_nxt = (cur != prv_r || !ce) ? 2'd0 : (q_r == 2'd3 ? 2'd3 : q_r + 2'd1);
        case (ctl_r[9:8])
            2'd1:    ev = alarm || warning;
            2'd2:    ev = warning;
            default: ev = alarm;
        endcase
        b = (ctl_r[6:4] inside {[3'd1:3'd6]}) ? dig_src[ctl_r[6:4] - 3'd1] : 1'b0;
        if (alarm && ctl_r[13:12] == 2'd1) b = 1'b0;
        if (alarm && ctl_r[13:12] == 2'd2) b = 1'b1;
        case (ctl_r[2:0])
            3'd1:    b = 1'b1;
            3'd2:    b = !ev;
            3'd4:    b = b;
            default: b = 1'b0;
        endcase
        exp = b ^ ctl_r[16];
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r  <= 2'd0;
            ctl_r <= 32'h0;
            prv_r <= 42'h0;
            q_r   <= 2'd0;
        end else begin
            ph_r  <= ph_nxt;
            ctl_r <= ctl_nxt;
            prv_r <= cur;
            q_r   <= q_nxt;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    off_on_a: assert property (q_nxt == 2'd3 && !(ctl_r[2:0] inside {[3'd2:3'd4]})
        |-> switch_closed == exp) else $error("off or on level wrong");
    diag_mode_a: assert property (q_nxt == 2'd3 && ctl_r[2:0] == 3'd2
        |-> switch_closed == exp) else $error("diagnostic level wrong");
    dout_mode_a: assert property (q_nxt == 2'd3 && ctl_r[2:0] == 3'd4 && !alarm
        |-> switch_closed == exp) else $error("digital source level wrong");
    fail_mode_a: assert property (q_nxt == 2'd3 && ctl_r[2:0] == 3'd4 && alarm
        |-> switch_closed == exp) else $error("failure level wrong");
    status_read_a: assert property (ph_r[1] |-> hrdata[0] == $past(switch_closed))
        else $error("status bit differs from output");
    ce_freeze_a: assert property (!ce |=> $stable(switch_closed) && $stable(hrdata))
        else $error("state moved while disabled");
    ready_back_a: assert property (ce |=> hreadyout) else $error("ready missing");
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
endmodule // swo_ctrl_props

/* verification/swo_load.sv */
// Behavioural model of the load that the switch output drives.
`timescale 1ns/100ps
module swo_load (
    input  wire logic hclk,
    input  wire logic switch_closed,
    output logic      conducting
);
    // The load follows the contact one clock late: it starts and stops conducting one edge after the contact closes or opens.
    always_ff @(posedge hclk) begin
        conducting <= switch_closed;
    end
endmodule // swo_load
